/* File: core/dps_pkg.sv */
/*
 * Package for the dual data pointer select block: special function
 * addresses, field positions, reset values and pointer mode codes.
 * Assumes an 8-bit special function bus driven by the processor core.
 */
package dps_pkg;
	// Special function addresses
	localparam logic [7:0] DPS_ADDR_PTR_LO  = 8'h82;
	localparam logic [7:0] DPS_ADDR_PTR_HI  = 8'h83;
	localparam logic [7:0] DPS_ADDR_CONTROL = 8'h85;
	localparam logic [7:0] DPS_ADDR_MODE    = 8'h86;
	// Reset values
	localparam logic [7:0]  DPS_CONTROL_RST = 8'h00;
	localparam logic [7:0]  DPS_MODE_RST    = 8'h00;
	localparam logic [15:0] DPS_PTR_RST     = 16'h0000;
	// Pointer control fields
	localparam int DPS_SEL_BIT    = 0;
	localparam int DPS_TOGGLE_BIT = 6;
	// Pointer mode fields
	localparam int DPS_MODE0_LSB = 0;
	localparam int DPS_MODE1_LSB = 2;
	// Pointer mode codes
	typedef enum logic [1:0] {
		DPS_MODE_HOLD = 2'b00,
		DPS_MODE_RSVD = 2'b01,
		DPS_MODE_INC  = 2'b10,
		DPS_MODE_DEC  = 2'b11
	} dps_mode_t;
endpackage

/* File: core/dps_step.sv */
/*
 * Next pointer value after an external data move, from the mode code.
 * Purely combinational; assumes the caller gates it with the move strobe.
 */
module dps_step (
	// Pointer in
	input  wire logic [15:0]       ptr_i,
	input  wire dps_pkg::dps_mode_t mode_i,
	// Pointer out
	output logic      [15:0]       ptr_o
);
	import dps_pkg::*;

	// Increment, decrement or hold; reserved code holds
	always_comb begin
		case (mode_i)
			DPS_MODE_INC: ptr_o = ptr_i + 16'h0001;
			DPS_MODE_DEC: ptr_o = ptr_i - 16'h0001;
			default:      ptr_o = ptr_i;
		endcase
	end
endmodule

/* File: core/dps_top.sv */
/*
 * Dual data pointer register file: two 16-bit background pointers, one
 * visible at a time through the legacy pointer bytes, with select,
 * auto-toggle and per-pointer auto step after external data moves.
 * Assumes the core issues one special function access per cycle and
 * pulses xmove_i once per external data move that uses the pointer.
 */
// How it works
// - Two independent 16-bit pointers; the active one addresses external data.
// - Reset clears select, so the first pointer sits at 82h/83h.
// - Select set routes visible pointer reads, writes and addressing to second pointer.
// - Unselected pointer holds its value and cannot be read or written.
// - With auto-toggle on, each external data move without a same-cycle control write inverts the select bit.
// - Pointer control register at 85h, resets to 00h.
// - Control bit 6 is auto-toggle enable, read/write.
// - Control bit 0 is pointer select, read/write.
// - Mode register at 86h, reset 00h; bits 3-2 second, 1-0 first.
// - Step applies only to the selected pointer, only on external data moves.
module dps_top (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Special function bus
	input  wire logic [7:0]  sfr_addr_i,
	input  wire logic        sfr_wr_i,
	input  wire logic [7:0]  sfr_wdata_i,
	output logic      [7:0]  sfr_rdata_o,
	output logic             sfr_hit_o,
	// External data move
	input  wire logic        xmove_i,
	output logic      [15:0] xaddr_o,
	// Status
	output logic             ptr_sel_o
);
	import dps_pkg::*;

	logic [15:0] ptr0_r, ptr0_nxt, ptr1_r, ptr1_nxt;
	logic        sel_r, sel_nxt, tog_r, tog_nxt;
	logic [1:0]  mode0_r, mode0_nxt, mode1_r, mode1_nxt;
	logic [15:0] act_ptr, step_ptr;
	dps_mode_t   act_mode;
	logic [7:0]  rdata_nxt;
	logic [7:0]  rdata_r;

	// Active pointer and its mode
	assign act_ptr  = sel_r ? ptr1_r : ptr0_r;
	assign act_mode = dps_mode_t'(sel_r ? mode1_r : mode0_r);
	assign xaddr_o  = act_ptr;
	assign ptr_sel_o = sel_r;

	dps_step u_step (
		.ptr_i  (act_ptr),
		.mode_i (act_mode),
		.ptr_o  (step_ptr)
	);

	// Next state of pointers and control
	always_comb begin
		ptr0_nxt  = ptr0_r;
		ptr1_nxt  = ptr1_r;
		sel_nxt   = sel_r;
		tog_nxt   = tog_r;
		mode0_nxt = mode0_r;
		mode1_nxt = mode1_r;
		// Step the pointer just used, then toggle
		if (xmove_i) begin
			if (sel_r)
				ptr1_nxt = step_ptr;
			else
				ptr0_nxt = step_ptr;
			if (tog_r)
				sel_nxt = ~sel_r;
		end
		// Software writes win over the move for the same byte
		if (sfr_wr_i) begin
			case (sfr_addr_i)
				DPS_ADDR_PTR_LO: begin
					if (sel_r) ptr1_nxt[7:0] = sfr_wdata_i;
					else       ptr0_nxt[7:0] = sfr_wdata_i;
				end
				DPS_ADDR_PTR_HI: begin
					if (sel_r) ptr1_nxt[15:8] = sfr_wdata_i;
					else       ptr0_nxt[15:8] = sfr_wdata_i;
				end
				DPS_ADDR_CONTROL: begin
					sel_nxt = sfr_wdata_i[DPS_SEL_BIT];
					tog_nxt = sfr_wdata_i[DPS_TOGGLE_BIT];
				end
				DPS_ADDR_MODE: begin
					mode0_nxt = sfr_wdata_i[DPS_MODE0_LSB +: 2];
					mode1_nxt = sfr_wdata_i[DPS_MODE1_LSB +: 2];
				end
				default: ;
			endcase
		end
	end

	// Register pointers and control
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ptr0_r  <= DPS_PTR_RST;
			ptr1_r  <= DPS_PTR_RST;
			sel_r   <= DPS_CONTROL_RST[DPS_SEL_BIT];
			tog_r   <= DPS_CONTROL_RST[DPS_TOGGLE_BIT];
			mode0_r <= DPS_MODE_RST[DPS_MODE0_LSB +: 2];
			mode1_r <= DPS_MODE_RST[DPS_MODE1_LSB +: 2];
		end else begin
			ptr0_r  <= ptr0_nxt;
			ptr1_r  <= ptr1_nxt;
			sel_r   <= sel_nxt;
			tog_r   <= tog_nxt;
			mode0_r <= mode0_nxt;
			mode1_r <= mode1_nxt;
		end
	end

	// Read mux; only the selected pointer is visible
	always_comb begin
		rdata_nxt = 8'h00;
		sfr_hit_o = 1'b1;
		case (sfr_addr_i)
			DPS_ADDR_PTR_LO:  rdata_nxt = act_ptr[7:0];
			DPS_ADDR_PTR_HI:  rdata_nxt = act_ptr[15:8];
			DPS_ADDR_CONTROL: begin
				rdata_nxt[DPS_SEL_BIT]    = sel_r;
				rdata_nxt[DPS_TOGGLE_BIT] = tog_r;
			end
			DPS_ADDR_MODE: begin
				rdata_nxt[DPS_MODE0_LSB +: 2] = mode0_r;
				rdata_nxt[DPS_MODE1_LSB +: 2] = mode1_r;
			end
			default: sfr_hit_o = 1'b0;
		endcase
	end

	// Registered read data
	always_ff @(posedge clk_i) begin
		if (rst_i)
			rdata_r <= 8'h00;
		else
			rdata_r <= rdata_nxt;
	end
	assign sfr_rdata_o = rdata_r;

	// Checks
	a_reset_sel: assert property (@(posedge clk_i) rst_i |=> !sel_r && !tog_r)
		else $error("select or toggle not cleared by reset");
	a_toggle_move: assert property (@(posedge clk_i) disable iff (rst_i)
		xmove_i && tog_r && !sfr_wr_i |=> sel_r != $past(sel_r))
		else $error("auto-toggle did not invert select");
	a_no_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
		!tog_r && !sfr_wr_i |=> $stable(sel_r))
		else $error("select changed without toggle or write");
	a_hidden_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		sel_r |=> ptr0_r == $past(ptr0_r))
		else $error("unselected first pointer changed");
	a_hidden_hold1: assert property (@(posedge clk_i) disable iff (rst_i)
		!sel_r |=> ptr1_r == $past(ptr1_r))
		else $error("unselected second pointer changed");
	a_inc_step: assert property (@(posedge clk_i) disable iff (rst_i)
		xmove_i && !sfr_wr_i && !sel_r && mode0_r == DPS_MODE_INC |=>
		ptr0_r == $past(ptr0_r) + 16'h0001)
		else $error("first pointer did not increment");
	a_dec_step: assert property (@(posedge clk_i) disable iff (rst_i)
		xmove_i && !sfr_wr_i && sel_r && mode1_r == DPS_MODE_DEC |=>
		ptr1_r == $past(ptr1_r) - 16'h0001)
		else $error("second pointer did not decrement");
	a_no_move_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!xmove_i && !sfr_wr_i |=> $stable(ptr0_r) && $stable(ptr1_r))
		else $error("pointer changed without move or write");
	a_ctrl_read: assert property (@(posedge clk_i) disable iff (rst_i)
		sfr_addr_i == DPS_ADDR_CONTROL |=> (sfr_rdata_o & 8'hBE) == 8'h00 &&
		sfr_rdata_o[0] == $past(sel_r) && sfr_rdata_o[6] == $past(tog_r))
		else $error("control readback wrong");
	a_addr_out: assert property (@(posedge clk_i) disable iff (rst_i)
		sfr_wr_i && !xmove_i && sfr_addr_i == DPS_ADDR_PTR_LO |=>
		xaddr_o[7:0] == $past(sfr_wdata_i))
		else $error("written low byte not on external address");

	// Reset clears both pointers and both modes
	a_reset_ptrs: assert property (@(posedge clk_i) rst_i |=>
		ptr0_r == DPS_PTR_RST && ptr1_r == DPS_PTR_RST &&
		mode0_r == DPS_MODE_RST[DPS_MODE0_LSB +: 2] && mode1_r == DPS_MODE_RST[DPS_MODE1_LSB +: 2])
		else $error("pointers or modes not cleared by reset");

	// Decrement of the first pointer
	a_dec_first: assert property (@(posedge clk_i) disable iff (rst_i)
		xmove_i && !sfr_wr_i && !sel_r && mode0_r == DPS_MODE_DEC |=>
		ptr0_r == $past(ptr0_r) - 16'h0001)
		else $error("first pointer did not decrement");

	// Increment of the second pointer
	a_inc_second: assert property (@(posedge clk_i) disable iff (rst_i)
		xmove_i && !sfr_wr_i && sel_r && mode1_r == DPS_MODE_INC |=>
		ptr1_r == $past(ptr1_r) + 16'h0001)
		else $error("second pointer did not increment");

	// Hold and reserved codes leave both pointers alone
	a_hold_modes: assert property (@(posedge clk_i) disable iff (rst_i)
		xmove_i && !sfr_wr_i && (act_mode == DPS_MODE_HOLD || act_mode == DPS_MODE_RSVD) |=>
		$stable(ptr0_r) && $stable(ptr1_r))
		else $error("pointer stepped in hold mode");

	// Move without toggle keeps the selection
	a_move_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		xmove_i && !tog_r && !sfr_wr_i |=> sel_r == $past(sel_r))
		else $error("select changed on move with toggle off");

	// Control write sets select and toggle as written
	a_sel_out: assert property (@(posedge clk_i) disable iff (rst_i)
		sfr_wr_i && sfr_addr_i == DPS_ADDR_CONTROL |=>
		ptr_sel_o == $past(sfr_wdata_i[DPS_SEL_BIT]) && tog_r == $past(sfr_wdata_i[DPS_TOGGLE_BIT]))
		else $error("control write not taken");

	// Control write wins over a toggle in the same cycle
	a_ctrl_wins: assert property (@(posedge clk_i) disable iff (rst_i)
		xmove_i && tog_r && sfr_wr_i && sfr_addr_i == DPS_ADDR_CONTROL |=>
		sel_r == $past(sfr_wdata_i[DPS_SEL_BIT]))
		else $error("toggle overrode control write");

	// Byte write wins over the step for that byte
	a_byte_wins: assert property (@(posedge clk_i) disable iff (rst_i)
		xmove_i && sfr_wr_i && sfr_addr_i == DPS_ADDR_PTR_LO |=>
		($past(sel_r) ? ptr1_r[7:0] : ptr0_r[7:0]) == $past(sfr_wdata_i))
		else $error("step overrode low byte write");

	// Mode readback, upper bits zero
	a_mode_read: assert property (@(posedge clk_i) disable iff (rst_i)
		sfr_addr_i == DPS_ADDR_MODE |=> sfr_rdata_o[7:4] == 4'h0 &&
		sfr_rdata_o[3:0] == $past({mode1_r, mode0_r}))
		else $error("mode readback wrong");

	// Visible high byte reads the selected pointer
	a_ptr_read: assert property (@(posedge clk_i) disable iff (rst_i)
		sfr_addr_i == DPS_ADDR_PTR_HI |=>
		sfr_rdata_o == $past(sel_r ? ptr1_r[15:8] : ptr0_r[15:8]))
		else $error("visible pointer readback wrong");

	// Unmapped addresses read zero
	a_other_read: assert property (@(posedge clk_i) disable iff (rst_i)
		!sfr_hit_o |=> sfr_rdata_o == 8'h00)
		else $error("unmapped address read nonzero");
endmodule

/* File: dv/dps_core_model.sv */
/*
 * Processor core model: special function writes, reads and move pulses.
 * Assumes the bench calls one task at a time on clk_i.
 */
module dps_core_model (
	// Clock
	input  wire logic       clk_i,
	// Bus to block
	output logic      [7:0] addr_o,
	output logic            wr_o,
	output logic      [7:0] wdata_o,
	output logic            xmove_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle values at time zero
	initial begin
		addr_o = 8'h00;
		wr_o = 1'b0;
		wdata_o = 8'h00;
		xmove_o = 1'b0;
	end
	// One write, data scrambled after it is taken
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask
	// Address held one edge; data follows it
	task automatic sfr_rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_o <= a;
		@(posedge clk_i);
	endtask
	// Move and write taken at the same edge
	task automatic move_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		xmove_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		xmove_o <= 1'b0;
		wdata_o <= ~d;
	endtask
	// One external data move
	task automatic move();
		@(posedge clk_i);
		xmove_o <= 1'b1;
		@(posedge clk_i);
		xmove_o <= 1'b0;
	endtask
endmodule

/* File: dv/test_dual_data_pointer_select.sv */
/*
 * Random register and move traffic against an integer reference model.
 * Assumes dps_top and dps_core_model are compiled first.
 */
module test_dual_data_pointer_select;
	timeunit 1ns;
	timeprecision 1ps;
	import dps_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  addr, wdata, rdata;
	logic        wr, xmove, hit, sel_o;
	logic [15:0] xaddr;
	int          error_cnt = 0;
	int          check_count = 0;
	logic [31:0] rng = 32'h2193_f764;
	logic [15:0] p [2];
	logic        sel, tog;
	logic [3:0]  md;
	logic [7:0]  al [5] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86};
	dps_core_model core (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .xmove_o(xmove));
	dps_top dut (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
		.sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .sfr_hit_o(hit), .xmove_i(xmove),
		.xaddr_o(xaddr), .ptr_sel_o(sel_o));
	// Clock
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		case (a)
			DPS_ADDR_PTR_LO:  return p[sel][7:0];
			DPS_ADDR_PTR_HI:  return p[sel][15:8];
			DPS_ADDR_CONTROL: return {1'b0, tog, 5'h00, sel};
			DPS_ADDR_MODE:    return {4'h0, md};
			default: return 8'h00;
		endcase
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a);
		core.sfr_rd(a);
		#1;
		check(rdata, exp_rd(a));
		check(hit, (a != 8'h84));
	endtask
	task automatic summarize();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Watchdog
	initial begin
		#80000;
		error_cnt++;
		summarize();
	end
	// Main sequence
	initial begin
		logic [31:0] r;
		logic [1:0]  m;
		logic        s0;
		p = '{16'h0000, 16'h0000};
		{sel, tog, md} = '0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (al[i]) rd_chk(al[i]);
		for (int n = 0; n < 400; n++) begin
			r = xs();
			case (r[2:0])
				3'd0, 3'd1, 3'd2, 3'd3, 3'd4: begin
					core.sfr_wr(al[r[2:0]], r[23:16]);
					if (r[2:0] == 3'd0) p[sel][7:0] = r[23:16];
					if (r[2:0] == 3'd1) p[sel][15:8] = r[23:16];
					if (r[2:0] == 3'd3) {tog, sel} = {r[22], r[16]};
					if (r[2:0] == 3'd4) md = r[19:16];
				end
				3'd5: begin
					// Step and toggle first, then the write overrides its field
					core.move_wr(al[r[26:24] % 5], r[23:16]);
					s0 = sel;
					m = sel ? md[3:2] : md[1:0];
					if (m == DPS_MODE_INC) p[s0]++;
					if (m == DPS_MODE_DEC) p[s0]--;
					if (tog) sel = ~sel;
					case (r[26:24] % 5)
						0: p[s0][7:0] = r[23:16];
						1: p[s0][15:8] = r[23:16];
						3: {tog, sel} = {r[22], r[16]};
						4: md = r[19:16];
						default: ;
					endcase
				end
				default: begin
					core.move();
					m = sel ? md[3:2] : md[1:0];
					if (m == DPS_MODE_INC) p[sel]++;
					if (m == DPS_MODE_DEC) p[sel]--;
					if (tog) sel = ~sel;
				end
			endcase
			#1;
			check(xaddr, p[sel]);
			check(sel_o, sel);
			rd_chk(al[r[10:8] % 5]);
		end
		// Reset in mid-run with second pointer and toggle selected
		core.sfr_wr(DPS_ADDR_CONTROL, 8'h41);
		{tog, sel} = 2'b11;
		#1;
		check(sel_o, sel);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		p = '{16'h0000, 16'h0000};
		{sel, tog, md} = '0;
		#1;
		check(xaddr, p[sel]);
		check(sel_o, sel);
		foreach (al[i]) rd_chk(al[i]);
		// Second pointer was cleared as well
		core.sfr_wr(DPS_ADDR_CONTROL, 8'h01);
		sel = 1'b1;
		rd_chk(DPS_ADDR_PTR_LO);
		rd_chk(DPS_ADDR_PTR_HI);
		summarize();
	end
endmodule
